// [upp_pkg.sv]
// shared constants and types for the usb port protector fault sequencer
// Operation
// - data/logic/bus overvoltage opens power and data switches; code opens gate and data switches, internal switch stays on
// - overvoltage flag only after 20ms persistence
// - bus short pulses limit, 20ms then autoreset
// - autoreset exits after bus above 0.5V 20ms
// - supply under 4.45V opens internal switch, flag 20ms
// - supply under 3.85V kills switches and logic
// - overtemperature kills gate, internal and data switches, immediate flag
// - low limit resistor opens gate and data switches, immediate flag
// - active-low open-drain fault flag
// - switches close only while enable asserted
// - three modes from enable and charger detect
// - disabled mode turns all paths off
// - detect enable and lines low close switch 1
// - dp near 0.6V closes switch 2
// - dp above 2V opens both detect switches
// - reclose switch 1 after 100us both low
package upp_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int BLANK_MS = 20;
	localparam int REARM_US = 100;
	localparam int BLANK_CYC = CLK_HZ / 1000 * BLANK_MS;
	localparam int REARM_CYC = (CLK_HZ / 1_000_000) * REARM_US;
	localparam int CNT_W = 20;
	localparam int PULSE_W = 8;
	localparam int PULSE_ON = 16;
	localparam logic ENABLE_ACTIVE_HIGH = 1'b1;

	typedef struct packed {
		logic ov_dline;
		logic ov_logic;
		logic ov_vbus;
		logic short_vbus;
		logic vbus_above_retry;
		logic uv_supply;
		logic uvlo_supply;
		logic over_temp;
		logic temp_cool;
		logic limit_set_pin_short;
		logic dp_high;
		logic dm_high;
		logic dp_low;
		logic dm_low;
		logic dp_src;
	} upp_cmp_s;

	typedef struct packed {
		logic ext_gate_on;
		logic ext_gate_slow;
		logic int_switch_on;
		logic data_switch_on;
		logic pulse_limit;
		logic retry_current;
		logic det_sw1;
		logic det_sw2;
		logic cmp_pos_zero;
		logic logic_active;
	} upp_drv_s;

	typedef enum logic [1:0] {
		UPP_RUN = 2'b00,
		UPP_SHORT = 2'b01,
		UPP_RETRY = 2'b10
	} upp_bus_e;
endpackage

// [upp_timer.sv]
// qualifying-interval counter with restart on lapse
`timescale 1ns/100ps
`default_nettype none
module upp_timer #(
	parameter int LIMIT = 4
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic cond_in,
	output logic done_out
);
	logic [upp_pkg::CNT_W-1:0] cnt;
	logic [upp_pkg::CNT_W-1:0] next_cnt;
	localparam logic [upp_pkg::CNT_W-1:0] LIM = upp_pkg::CNT_W'(LIMIT);

	always_comb begin
		next_cnt = cnt;
		if (!cond_in) begin
			next_cnt = '0;
		end else if (cnt != LIM) begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign done_out = cond_in && (cnt == LIM);

	a_timer_restart: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		!cond_in |=> cnt == '0) else $error("timer did not restart");
endmodule
`default_nettype wire

// [upp_sequencer.sv]
// fault sequencing and charger port detection control
`timescale 1ns/100ps
`default_nettype none
module upp_sequencer #(
	parameter int BLANK_CYC = upp_pkg::BLANK_CYC
) (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire upp_pkg::upp_cmp_s CMP_IN,
	input wire logic ENABLE_IN,
	input wire logic CHARGER_DETECT_ENABLE_IN,
	output var upp_pkg::upp_drv_s DRV_OUT,
	output logic FAULTN_OUT,
	output logic FAULTN_OE_N_OUT,
	output logic [1:0] MODE_OUT
);
	localparam int NB = $bits(upp_pkg::upp_cmp_s) + 2;

	// three-stage sync, change taken when stages 2 and 3 agree
	logic [NB-1:0] s1, s2, s3, q;
	logic [NB-1:0] next_q;
	always_comb begin
		next_q = q;
		for (int i = 0; i < NB; i++) begin
			if (s2[i] == s3[i]) begin
				next_q[i] = s3[i];
			end
		end
	end
	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q <= '0;
		end else begin
			s1 <= {CMP_IN, ENABLE_IN, CHARGER_DETECT_ENABLE_IN};
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

	upp_pkg::upp_cmp_s c;
	logic en_raw, charger_detect_enable;
	assign c = upp_pkg::upp_cmp_s'(q[NB-1:2]);
	assign en_raw = q[1];
	assign charger_detect_enable = q[0];

	logic en;
	assign en = (en_raw == upp_pkg::ENABLE_ACTIVE_HIGH);

	logic ov_any, uv_mid, ov_done, uv_done, short_done, retry_done, rearm_done;
	logic both_low;
	assign ov_any = c.ov_dline | c.ov_logic | c.ov_vbus;
	assign uv_mid = c.uv_supply & ~c.uvlo_supply;
	assign both_low = c.dp_low & c.dm_low;

	upp_pkg::upp_bus_e bus_st, next_bus_st;

	upp_timer #(.LIMIT(BLANK_CYC)) u_ov (
		.clk_in(MCLK_IN), .rstn_in(RSTN_IN),
		.cond_in(ov_any), .done_out(ov_done));
	upp_timer #(.LIMIT(BLANK_CYC)) u_uv (
		.clk_in(MCLK_IN), .rstn_in(RSTN_IN),
		.cond_in(uv_mid), .done_out(uv_done));
	upp_timer #(.LIMIT(BLANK_CYC)) u_sh (
		.clk_in(MCLK_IN), .rstn_in(RSTN_IN),
		.cond_in(c.short_vbus && bus_st == upp_pkg::UPP_SHORT),
		.done_out(short_done));
	upp_timer #(.LIMIT(BLANK_CYC)) u_rt (
		.clk_in(MCLK_IN), .rstn_in(RSTN_IN),
		.cond_in(c.vbus_above_retry && bus_st == upp_pkg::UPP_RETRY),
		.done_out(retry_done));
	upp_timer #(.LIMIT(upp_pkg::REARM_CYC)) u_ra (
		.clk_in(MCLK_IN), .rstn_in(RSTN_IN),
		.cond_in(both_low), .done_out(rearm_done));

	// bus short state machine
	always_comb begin
		next_bus_st = bus_st;
		unique case (bus_st)
			upp_pkg::UPP_RUN: begin
				if (c.short_vbus) begin
					next_bus_st = upp_pkg::UPP_SHORT;
				end
			end
			upp_pkg::UPP_SHORT: begin
				if (short_done) begin
					next_bus_st = upp_pkg::UPP_RETRY;
				end else if (!c.short_vbus) begin
					next_bus_st = upp_pkg::UPP_RUN;
				end
			end
			upp_pkg::UPP_RETRY: begin
				if (retry_done) begin
					next_bus_st = upp_pkg::UPP_RUN;
				end
			end
			default: next_bus_st = upp_pkg::UPP_RUN;
		endcase
	end

	// thermal latch with hysteresis; pulse counter and slow-start flag
	logic hot, next_hot;
	logic [upp_pkg::PULSE_W-1:0] pcnt, next_pcnt;
	logic slow, next_slow;
	// set above 160C, clear only below 140C
	always_comb begin
		next_hot = hot;
		if (c.over_temp) begin
			next_hot = 1'b1;
		end else if (c.temp_cool) begin
			next_hot = 1'b0;
		end
		next_pcnt = (bus_st == upp_pkg::UPP_SHORT) ? pcnt + 1'b1 : '0;
		// slow gate ramp after recovery, until the bus next leaves run
		next_slow = slow;
		if (retry_done) begin
			next_slow = 1'b1;
		end else if (bus_st == upp_pkg::UPP_RUN && !c.vbus_above_retry) begin
			next_slow = slow;
		end else if (bus_st != upp_pkg::UPP_RUN) begin
			next_slow = 1'b0;
		end
	end

	// charger detection sequencing
	logic sw1, next_sw1, sw2, next_sw2, armed, next_armed;
	logic det_on;
	assign det_on = en & charger_detect_enable & ~c.uvlo_supply;
	always_comb begin
		next_sw1 = sw1;
		next_sw2 = sw2;
		next_armed = armed;
		if (!det_on) begin
			next_sw1 = 1'b0;
			next_sw2 = 1'b0;
			next_armed = 1'b1;
		end else if (c.dp_high | c.dm_high) begin
			// stay disarmed while a line is high
			next_sw1 = 1'b0;
			next_sw2 = 1'b0;
			next_armed = 1'b0;
		end else begin
			// close switch 1 when both lines low
			if (armed && both_low) begin
				next_sw1 = 1'b1;
			end
			if (!armed && rearm_done) begin
				next_armed = 1'b1;
				next_sw1 = 1'b1;
			end
			next_sw2 = sw1 & c.dp_src;
		end
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			bus_st <= upp_pkg::UPP_RUN;
			hot <= 1'b0;
			pcnt <= '0;
			slow <= 1'b0;
			sw1 <= 1'b0;
			sw2 <= 1'b0;
			armed <= 1'b1;
		end else begin
			bus_st <= next_bus_st;
			hot <= next_hot;
			pcnt <= next_pcnt;
			slow <= next_slow;
			sw1 <= next_sw1;
			sw2 <= next_sw2;
			armed <= next_armed;
		end
	end

	// output decode
	logic fault, kill_ext, kill_int, kill_data;
	upp_pkg::upp_drv_s next_drv;
	logic [1:0] next_mode;
	assign fault = ov_done | uv_done | hot | c.limit_set_pin_short |
		(bus_st == upp_pkg::UPP_RETRY);
	// immediate shutoff on overvoltage, on low resistor
	assign kill_ext = ov_any | hot | c.limit_set_pin_short;
	assign kill_int = c.uv_supply | hot;
	assign kill_data = ov_any | hot | c.limit_set_pin_short | c.uvlo_supply;

	always_comb begin
		next_drv = '0;
		next_drv.logic_active = ~c.uvlo_supply;
		if (en && !c.uvlo_supply) begin
			next_drv.ext_gate_on = ~kill_ext & (bus_st != upp_pkg::UPP_RETRY);
			next_drv.ext_gate_slow = slow;
			next_drv.int_switch_on = ~kill_int &
				(bus_st != upp_pkg::UPP_SHORT ||
				pcnt < upp_pkg::PULSE_W'(upp_pkg::PULSE_ON));
			next_drv.data_switch_on = ~kill_data;
			next_drv.pulse_limit = (bus_st == upp_pkg::UPP_SHORT);
			next_drv.retry_current = (bus_st == upp_pkg::UPP_RETRY);
			next_drv.det_sw1 = sw1;
			next_drv.det_sw2 = sw2;
			next_drv.cmp_pos_zero = ~sw1;
		end
		// mode 0 off, 1 high speed, 2 detect
		next_mode = !en ? 2'h0 : (charger_detect_enable ? 2'h2 : 2'h1);
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			DRV_OUT <= '0;
			FAULTN_OE_N_OUT <= 1'b1;
			MODE_OUT <= 2'h0;
		end else begin
			DRV_OUT <= next_drv;
			FAULTN_OE_N_OUT <= ~fault;
			MODE_OUT <= next_mode;
		end
	end
	assign FAULTN_OUT = 1'b0;

	a_ov_kills_ext: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		ov_any |=> !DRV_OUT.ext_gate_on && !DRV_OUT.data_switch_on)
		else $error("overvoltage left switch on");
	a_ov_no_early: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		ov_any && !ov_done && !(uv_done | hot | c.limit_set_pin_short) &&
		bus_st != upp_pkg::UPP_RETRY |=> FAULTN_OE_N_OUT)
		else $error("overvoltage flagged early");
	a_short_retry: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		short_done |=> bus_st == upp_pkg::UPP_RETRY)
		else $error("short did not enter autoreset");
	a_pulse_duty: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		bus_st == upp_pkg::UPP_SHORT &&
		pcnt >= upp_pkg::PULSE_W'(upp_pkg::PULSE_ON)
		|=> !DRV_OUT.int_switch_on)
		else $error("pulse limit left switch on");
	a_retry_exit: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		retry_done |=> bus_st == upp_pkg::UPP_RUN)
		else $error("autoreset did not exit");
	a_retry_gate: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		bus_st == upp_pkg::UPP_RETRY
		|=> !DRV_OUT.ext_gate_on && !FAULTN_OE_N_OUT)
		else $error("autoreset left gate on");
	a_uv_int_off: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		c.uv_supply |=> !DRV_OUT.int_switch_on)
		else $error("undervoltage left switch on");
	a_uvlo_dead: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		c.uvlo_supply |=> !DRV_OUT.logic_active && !DRV_OUT.data_switch_on)
		else $error("low supply left logic active");
	a_hot_flag: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		c.over_temp |=> ##1 !FAULTN_OE_N_OUT)
		else $error("overtemperature not flagged");
	a_limit_set_pin_flag: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		c.limit_set_pin_short |=> !FAULTN_OE_N_OUT && !DRV_OUT.ext_gate_on)
		else $error("low resistor not flagged");
	a_mode_decode: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		en && !charger_detect_enable |=> MODE_OUT == 2'h1)
		else $error("pass-through mode not shown");
	a_disabled_off: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!en |=> DRV_OUT.data_switch_on == 1'b0 && MODE_OUT == 2'h0)
		else $error("disabled but switch on");
	a_sw2_needs_sw1: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!sw1 |=> !sw2)
		else $error("switch 2 closed without switch 1");
	a_fs_opens: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		c.dp_high |=> !sw1 && !sw2)
		else $error("detect switch stayed closed");
	a_rearm_wait: assert property (
		@(posedge MCLK_IN) disable iff (!RSTN_IN)
		!armed && !rearm_done |=> !sw1)
		else $error("detect switch closed before re-arm");
	c_short_path: cover property (@(posedge MCLK_IN) bus_st == upp_pkg::UPP_RETRY);
	c_charger: cover property (@(posedge MCLK_IN) sw2);
	c_hot: cover property (@(posedge MCLK_IN) hot);
	c_rearm: cover property (@(posedge MCLK_IN) rearm_done && !armed);
endmodule
`default_nettype wire

// [upp_portable_model.sv]
// portable device model seen through the protected data lines
`timescale 1ns/100ps
`default_nettype none
module upp_portable_model (
	input wire logic det_sw1_in,
	input wire logic [1:0] mode_in,
	output logic dp_high_out,
	output logic dm_high_out,
	output logic dp_low_out,
	output logic dm_low_out,
	output logic dp_src_out
);
	// portable drives dp
	// 0.6V probe only reaches the comparator through switch 1
	assign dp_src_out = (mode_in == 2'h1) && det_sw1_in;
	assign dp_high_out = (mode_in == 2'h2);
	assign dp_low_out = !dp_high_out;
	// low-speed pull-up; a 0.6V dm still reads as low
	assign dm_high_out = (mode_in == 2'h3);
	assign dm_low_out = !dm_high_out;
endmodule
`default_nettype wire

// [usb_port_protect_fault_sequencer_bench.sv]
// self-checking bench for the port protector fault sequencer
`timescale 1ns/100ps
`default_nettype none
module usb_port_protect_fault_sequencer_bench;
	localparam int BLANK = 50;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic en = 1'b0;
	logic charger_detect_enable = 1'b0;
	logic [1:0] pmode = 2'h0;
	upp_pkg::upp_cmp_s flt;
	upp_pkg::upp_cmp_s cmp;
	upp_pkg::upp_drv_s drv;
	logic faultn;
	logic flag_oe_n;
	logic [1:0] mode;
	logic dp_h, dm_h, dp_l, dm_l, dp_s;
	int err_count = 0;
	int checks_done = 0;

	always #25 mclk = ~mclk;

	always_comb begin
		cmp = flt;
		cmp.dp_high = dp_h;
		cmp.dm_high = dm_h;
		cmp.dp_low = dp_l;
		cmp.dm_low = dm_l;
		cmp.dp_src = dp_s;
	end

	upp_portable_model peer_u (
		.det_sw1_in(drv.det_sw1),
		.mode_in(pmode),
		.dp_high_out(dp_h),
		.dm_high_out(dm_h),
		.dp_low_out(dp_l),
		.dm_low_out(dm_l),
		.dp_src_out(dp_s)
	);

	upp_sequencer #(.BLANK_CYC(BLANK)) dut_u (
		.MCLK_IN(mclk),
		.RSTN_IN(rstn),
		.CMP_IN(cmp),
		.ENABLE_IN(en),
		.CHARGER_DETECT_ENABLE_IN(charger_detect_enable),
		.DRV_OUT(drv),
		.FAULTN_OUT(faultn),
		.FAULTN_OE_N_OUT(flag_oe_n),
		.MODE_OUT(mode)
	);

	function automatic logic [1:0] b(input logic x);
		return {1'b0, x};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [1:0] seen, input logic [1:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %b want %b", $time, seen, want);
		end
	endtask

	task automatic report_and_stop;
		if (err_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// bound well above the few thousand cycles the sequence needs
	initial begin
		#(50 * 20000);
		err_count++;
		report_and_stop();
	end

	initial begin
		flt = '0;
		flt.temp_cool = 1'b1;
		flt.vbus_above_retry = 1'b1;
		cyc(16);
		rstn = 1'b1;
		cyc(8);
		chk(mode, 2'h0);
		chk(b(drv.ext_gate_on | drv.data_switch_on), 2'h0);
		chk(b(flag_oe_n), 2'h1);
		chk(b(faultn), 2'h0);
		en = 1'b1;
		cyc(8);
		chk(mode, 2'h1);
		chk(b(drv.ext_gate_on & drv.int_switch_on & drv.data_switch_on), 2'h1);
		chk(b(drv.det_sw1), 2'h0);
		for (int i = 0; i < 3; i++) begin
			{flt.ov_dline, flt.ov_logic, flt.ov_vbus} = 3'h4 >> i;
			cyc(8);
			chk(b(drv.ext_gate_on | drv.data_switch_on), 2'h0);
			chk(b(flag_oe_n), 2'h1);
			cyc(BLANK + 10);
			chk(b(flag_oe_n), 2'h0);
			{flt.ov_dline, flt.ov_logic, flt.ov_vbus} = 3'h0;
			cyc(10);
			chk(b(flag_oe_n & drv.data_switch_on), 2'h1);
		end
		// a lapse of a few cycles must restart blanking
		flt.ov_dline = 1'b1;
		cyc(30);
		flt.ov_dline = 1'b0;
		cyc(5);
		flt.ov_dline = 1'b1;
		cyc(30);
		chk(b(flag_oe_n), 2'h1);
		cyc(30);
		chk(b(flag_oe_n), 2'h0);
		flt.ov_dline = 1'b0;
		cyc(10);
		flt.over_temp = 1'b1;
		flt.temp_cool = 1'b0;
		cyc(8);
		chk(b(flag_oe_n | drv.ext_gate_on | drv.int_switch_on), 2'h0);
		chk(b(drv.data_switch_on), 2'h0);
		flt.over_temp = 1'b0;
		cyc(8);
		chk(b(flag_oe_n), 2'h0);
		flt.temp_cool = 1'b1;
		cyc(8);
		chk(b(flag_oe_n), 2'h1);
		flt.limit_set_pin_short = 1'b1;
		cyc(8);
		chk(b(flag_oe_n | drv.ext_gate_on | drv.data_switch_on), 2'h0);
		flt.limit_set_pin_short = 1'b0;
		cyc(8);
		flt.uv_supply = 1'b1;
		cyc(8);
		chk(b(drv.int_switch_on), 2'h0);
		chk(b(flag_oe_n), 2'h1);
		cyc(BLANK + 10);
		chk(b(flag_oe_n), 2'h0);
		flt.uvlo_supply = 1'b1;
		cyc(8);
		chk(b(drv.int_switch_on | drv.data_switch_on | drv.logic_active), 2'h0);
		{flt.uv_supply, flt.uvlo_supply} = 2'h0;
		cyc(10);
		chk(b(flag_oe_n & drv.int_switch_on), 2'h1);
		flt.short_vbus = 1'b1;
		flt.vbus_above_retry = 1'b0;
		cyc(8);
		chk(b(drv.pulse_limit & flag_oe_n), 2'h1);
		cyc(BLANK + 10);
		chk(b(~flag_oe_n & drv.retry_current), 2'h1);
		flt.short_vbus = 1'b0;
		flt.vbus_above_retry = 1'b1;
		cyc(8);
		chk(b(flag_oe_n), 2'h0);
		cyc(BLANK + 10);
		chk(b(flag_oe_n & drv.ext_gate_slow), 2'h1);
		charger_detect_enable = 1'b1;
		cyc(8);
		chk(mode, 2'h2);
		chk(b(drv.det_sw1), 2'h1);
		pmode = 2'h1;
		cyc(8);
		chk(b(drv.det_sw2), 2'h1);
		pmode = 2'h2;
		cyc(8);
		chk(b(drv.det_sw1 | drv.det_sw2), 2'h0);
		chk(b(drv.cmp_pos_zero), 2'h1);
		pmode = 2'h0;
		cyc(1000);
		chk(b(drv.det_sw1), 2'h0);
		cyc(1010);
		chk(b(drv.det_sw1), 2'h1);
		pmode = 2'h3;
		cyc(8);
		chk(b(drv.det_sw1), 2'h0);
		pmode = 2'h0;
		en = 1'b0;
		charger_detect_enable = 1'b0;
		cyc(8);
		chk(mode, 2'h0);
		chk(b(drv.ext_gate_on | drv.int_switch_on | drv.data_switch_on), 2'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
